// file: rtl/tsc_pkg.sv
// package: register map, field layout and timing constants for the transmit source
// select and timer control block; assumes a byte-wide register port
package tsc_pkg;
    // register offsets
    localparam logic [7:0] ADDR_SRC_CTRL   = 8'h0b;
    localparam logic [7:0] ADDR_RELOAD_REQ = 8'h0c;
    localparam logic [7:0] ADDR_COUNT_GATE = 8'h0d;
    localparam logic [7:0] ADDR_CONTINUOUS = 8'h0e;
    localparam logic [7:0] ADDR_IVL_BASE   = 8'h10;
    localparam logic [7:0] ADDR_STATUS     = 8'h30;
    localparam logic [7:0] ADDR_CNT_SEL    = 8'h31;
    localparam logic [7:0] ADDR_CNT_LOW    = 8'h32;
    localparam logic [7:0] ADDR_CNT_HIGH   = 8'h33;
    // transmit_source_control fields
    localparam int SRC_LSB     = 0;
    localparam int SRC_MSB     = 2;
    localparam int POLY_BIT    = 3;
    localparam int MUTE_BIT    = 4;
    localparam int PULSE_LSB   = 5;
    localparam int PULSE_MSB   = 6;
    localparam logic [7:0] SRC_CTRL_MASK = 8'h7f;
    // source codes
    localparam logic [2:0] SRC_PULSE      = 3'h0;
    localparam logic [2:0] SRC_LOOP_SCR   = 3'h1;
    localparam logic [2:0] SRC_DATA_RAW   = 3'h2;
    localparam logic [2:0] SRC_ONES_SCR   = 3'h3;
    localparam logic [2:0] SRC_RESERVED   = 3'h4;
    localparam logic [2:0] SRC_DATA_SCR   = 3'h5;
    localparam logic [2:0] SRC_TWO_RAW    = 3'h6;
    localparam logic [2:0] SRC_TWO_ONES   = 3'h7;
    // timer bit positions
    localparam int NUM_TIMERS   = 8;
    localparam int NUM_BOOT     = 4;
    localparam int METER_BIT    = 4;
    // scrambler taps
    localparam int SCR_LEN      = 23;
    localparam int TAP_REMOTE   = 18;
    localparam int TAP_LOCAL    = 5;
    // symbol levels as signed 3-bit codes
    localparam logic [2:0] LVL_P3 = 3'h3;
    localparam logic [2:0] LVL_P1 = 3'h1;
    localparam logic [2:0] LVL_M1 = 3'h7;
    localparam logic [2:0] LVL_M3 = 3'h5;
    localparam logic [2:0] LVL_Z  = 3'h0;
    // timing: boot timers tick once per this many symbols
    localparam int BOOT_PRESCALE = 1024;
    localparam logic [9:0] PRESCALE_LAST = 10'h3ff;
endpackage : tsc_pkg

// file: rtl/tsc_top.sv
// transmit source selection, scrambler and eight countdown timers
// assumes sym_en_in pulses once per symbol period on clk_in and the register
// port strobes are synchronous to clk_in
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - isolated pulse level: 00=-3, 01=-1, 10=+3, 11=+1
// - mute bit forces transmitter output to zero
// - scrambler taps 23 and 18 when remote polynomial set, else 23 and 5
// - source modes act only while mute is clear
// - code 000 sends pulses at meter timer interval; software keeps it continuous
// - code 001 scrambles detector bits and sends four-level symbols
// - code 010 sends channel unit bits unscrambled, four-level
// - code 011 scrambles constant ones, four-level
// - code 101 scrambles channel unit bits, four-level; 100 reserved
// - code 110 forces magnitude zero, unscrambled sign, only +3/-3
// - code 111 scrambles ones once per symbol into sign, magnitude zero
// - timer control bits: 7 timer b, 6 timer a, 5 alarm, 4 meter, 3..0 boot
// - writing one to restart bit reloads timer from interval register
// - reload within one symbol, or 1024 symbols for boot timers
// - restart bit clears itself after reload
// - writing zero to pending restart cancels the reload
// - after reload, enabled timer counts down, else holds loaded value
// - set enable counts down from current value toward zero
// - counting begins within one symbol, or 1024 symbols for boot timers
// - clearing enable freezes the count
// - enable set then cleared before a tick causes no decrement
// - continuous timer reaching zero reloads and keeps counting
// - non-continuous timer reaching zero stops at zero
// - boot timer unit is 1024 symbols; others count single symbols
module tsc_top (
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       sym_en_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    input  wire logic       cu_sign_in,
    input  wire logic       cu_mag_in,
    input  wire logic       det_sign_in,
    input  wire logic       det_mag_in,
    output logic      [2:0] tx_level_out,
    output logic            tx_sign_out,
    output logic            tx_mag_out,
    output logic      [7:0] expired_out
);
    // registers
    logic [7:0]  src_ctrl;
    logic [7:0]  reload_req;
    logic [7:0]  count_gate;
    logic [7:0]  continuous;
    logic [7:0]  expired;
    logic [2:0]  cnt_sel;
    logic [15:0] interval [8];
    logic [15:0] count    [8];
    logic [9:0]  prescale;
    logic [22:0] scr;

    // field decode
    wire logic [2:0] src_code   = src_ctrl[tsc_pkg::SRC_MSB:tsc_pkg::SRC_LSB];
    wire logic       poly_sel   = src_ctrl[tsc_pkg::POLY_BIT];
    wire logic       mute       = src_ctrl[tsc_pkg::MUTE_BIT];
    wire logic [1:0] pulse_code = src_ctrl[tsc_pkg::PULSE_MSB:tsc_pkg::PULSE_LSB];

    wire logic wr_src   = wr_in && addr_in == tsc_pkg::ADDR_SRC_CTRL;
    wire logic wr_rel   = wr_in && addr_in == tsc_pkg::ADDR_RELOAD_REQ;
    wire logic wr_gate  = wr_in && addr_in == tsc_pkg::ADDR_COUNT_GATE;
    wire logic wr_cont  = wr_in && addr_in == tsc_pkg::ADDR_CONTINUOUS;
    wire logic wr_stat  = wr_in && addr_in == tsc_pkg::ADDR_STATUS;
    wire logic wr_sel   = wr_in && addr_in == tsc_pkg::ADDR_CNT_SEL;
    wire logic in_ivl   = addr_in >= tsc_pkg::ADDR_IVL_BASE &&
                          addr_in < tsc_pkg::ADDR_IVL_BASE + 8'h10;
    wire logic [7:0] ivl_off = addr_in - tsc_pkg::ADDR_IVL_BASE;
    wire logic [2:0] ivl_idx = ivl_off[3:1];

    // boot timers tick on the last symbol of each 1024-symbol group
    wire logic boot_tick = sym_en_in && prescale == tsc_pkg::PRESCALE_LAST;

    // per-timer tick: boot timers on boot_tick, the rest every symbol
    function automatic logic timer_tick(input int idx, input logic sym, input logic boot);
        timer_tick = (idx < tsc_pkg::NUM_BOOT) ? boot : sym;
    endfunction : timer_tick

    // scrambler feedback
    function automatic logic scr_fb(input logic [22:0] s, input logic remote);
        scr_fb = s[tsc_pkg::SCR_LEN-1] ^
                 (remote ? s[tsc_pkg::TAP_REMOTE-1] : s[tsc_pkg::TAP_LOCAL-1]);
    endfunction : scr_fb

    // symbol bits to signed level
    function automatic logic [2:0] quat_level(input logic sign, input logic mag);
        case ({sign, mag})
            2'b10:   quat_level = tsc_pkg::LVL_P3;
            2'b11:   quat_level = tsc_pkg::LVL_P1;
            2'b01:   quat_level = tsc_pkg::LVL_M1;
            default: quat_level = tsc_pkg::LVL_M3;
        endcase
    endfunction : quat_level

    // scrambler: sign and magnitude are scrambled serially, sign bit first
    wire logic use_det  = src_code == tsc_pkg::SRC_LOOP_SCR;
    wire logic ones_in  = src_code == tsc_pkg::SRC_ONES_SCR ||
                          src_code == tsc_pkg::SRC_TWO_ONES;
    wire logic two_lvl  = src_code == tsc_pkg::SRC_TWO_ONES;
    wire logic in_sign  = ones_in ? 1'b1 : (use_det ? det_sign_in : cu_sign_in);
    wire logic in_mag   = ones_in ? 1'b1 : (use_det ? det_mag_in : cu_mag_in);
    wire logic fb_a     = scr_fb(scr, poly_sel);
    wire logic s_sign   = in_sign ^ fb_a;
    wire logic [22:0] scr_a = {scr[21:0], s_sign};
    wire logic fb_b     = scr_fb(scr_a, poly_sel);
    wire logic s_mag    = in_mag ^ fb_b;
    wire logic [22:0] scr_b = {scr_a[21:0], s_mag};
    // two-level scrambled ones runs the scrambler once per symbol
    wire logic [22:0] next_scr = two_lvl ? scr_a : scr_b;

    // meter expiry paces the isolated pulse
    // a pending reload takes the tick, so no pulse then
    wire logic meter_fire = sym_en_in && count_gate[tsc_pkg::METER_BIT] &&
                            !reload_req[tsc_pkg::METER_BIT] &&
                            count[tsc_pkg::METER_BIT] == 16'h0001;

    // symbol selection
    logic [2:0] next_level;
    logic       next_sign;
    logic       next_mag;
    always_comb begin
        next_sign  = 1'b0;
        next_mag   = 1'b0;
        next_level = tsc_pkg::LVL_Z;
        case (src_code)
            tsc_pkg::SRC_PULSE: begin
                if (meter_fire) begin
                    case (pulse_code)
                        2'h0:    next_level = tsc_pkg::LVL_M3;
                        2'h1:    next_level = tsc_pkg::LVL_M1;
                        2'h2:    next_level = tsc_pkg::LVL_P3;
                        default: next_level = tsc_pkg::LVL_P1;
                    endcase
                end
            end
            tsc_pkg::SRC_LOOP_SCR, tsc_pkg::SRC_ONES_SCR, tsc_pkg::SRC_DATA_SCR: begin
                next_sign  = s_sign;
                next_mag   = s_mag;
                next_level = quat_level(s_sign, s_mag);
            end
            tsc_pkg::SRC_DATA_RAW: begin
                next_sign  = cu_sign_in;
                next_mag   = cu_mag_in;
                next_level = quat_level(cu_sign_in, cu_mag_in);
            end
            tsc_pkg::SRC_TWO_RAW: begin
                next_sign  = cu_sign_in;
                next_level = quat_level(cu_sign_in, 1'b0);
            end
            tsc_pkg::SRC_TWO_ONES: begin
                next_sign  = s_sign;
                next_level = quat_level(s_sign, 1'b0);
            end
            default: next_level = tsc_pkg::LVL_Z;
        endcase
        if (mute) begin
            next_level = tsc_pkg::LVL_Z;
            next_sign  = 1'b0;
            next_mag   = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tx_level_out <= tsc_pkg::LVL_Z;
            tx_sign_out  <= 1'b0;
            tx_mag_out   <= 1'b0;
            scr          <= '0;
            prescale     <= '0;
        end else if (sym_en_in) begin
            tx_level_out <= next_level;
            tx_sign_out  <= next_sign;
            tx_mag_out   <= next_mag;
            prescale     <= prescale + 10'h001;
            if (!mute && src_code != tsc_pkg::SRC_PULSE && src_code != tsc_pkg::SRC_DATA_RAW &&
                src_code != tsc_pkg::SRC_TWO_RAW && src_code != tsc_pkg::SRC_RESERVED)
                scr <= next_scr;
        end
    end

    // timers
    logic [7:0] tick_v;
    logic [7:0] reload_now;
    logic [7:0] dec_now;
    logic [7:0] zero_now;
    always_comb begin
        for (int i = 0; i < tsc_pkg::NUM_TIMERS; i++) begin
            tick_v[i]     = timer_tick(i, sym_en_in, boot_tick);
            reload_now[i] = tick_v[i] && reload_req[i];
            dec_now[i]    = tick_v[i] && !reload_req[i] && count_gate[i] &&
                            count[i] != 16'h0000;
            zero_now[i]   = dec_now[i] && count[i] == 16'h0001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            reload_req <= '0;
            count_gate <= '0;
            continuous <= '0;
            expired    <= '0;
            src_ctrl   <= '0;
            cnt_sel    <= '0;
            for (int i = 0; i < tsc_pkg::NUM_TIMERS; i++) begin
                interval[i] <= '0;
                count[i]    <= '0;
            end
        end else begin
            if (wr_src)
                src_ctrl <= wdata_in & tsc_pkg::SRC_CTRL_MASK;
            if (wr_gate)
                count_gate <= wdata_in;
            if (wr_cont)
                continuous <= wdata_in;
            if (wr_sel)
                cnt_sel <= wdata_in[2:0];
            // a write replaces pending requests; zero cancels, reload clears
            reload_req <= (wr_rel ? wdata_in : reload_req) & ~reload_now;
            // set wins over software clear (write one to clear)
            expired <= (wr_stat ? expired & ~wdata_in : expired) | zero_now;
            if (in_ivl && wr_in) begin
                if (ivl_off[0])
                    interval[ivl_idx][15:8] <= wdata_in;
                else
                    interval[ivl_idx][7:0] <= wdata_in;
            end
            for (int i = 0; i < tsc_pkg::NUM_TIMERS; i++) begin
                if (reload_now[i])
                    count[i] <= interval[i];
                else if (dec_now[i]) begin
                    if (zero_now[i] && continuous[i])
                        count[i] <= interval[i];
                    else
                        count[i] <= count[i] - 16'h0001;
                end
            end
        end
    end

    assign expired_out = expired;

    // read path: data valid the cycle after the read strobe
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (in_ivl)
            rd_mux = ivl_off[0] ? interval[ivl_idx][15:8] : interval[ivl_idx][7:0];
        else begin
            case (addr_in)
                tsc_pkg::ADDR_SRC_CTRL:   rd_mux = src_ctrl;
                tsc_pkg::ADDR_RELOAD_REQ: rd_mux = reload_req;
                tsc_pkg::ADDR_COUNT_GATE: rd_mux = count_gate;
                tsc_pkg::ADDR_CONTINUOUS: rd_mux = continuous;
                tsc_pkg::ADDR_STATUS:     rd_mux = expired;
                tsc_pkg::ADDR_CNT_SEL:    rd_mux = {5'h00, cnt_sel};
                tsc_pkg::ADDR_CNT_LOW:    rd_mux = count[cnt_sel][7:0];
                tsc_pkg::ADDR_CNT_HIGH:   rd_mux = count[cnt_sel][15:8];
                default:                  rd_mux = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in)
            rdata_out <= 8'h00;
        else if (rd_in)
            rdata_out <= rd_mux;
        else
            rdata_out <= 8'h00;
    end

    // assertions
    property p_mute_zero;
        @(posedge clk_in) disable iff (reset_in)
        (mute && sym_en_in) |=> tx_level_out == tsc_pkg::LVL_Z;
    endproperty
    a_mute_zero: assert property (p_mute_zero) else $error("mute did not zero output");

    property p_reserved_zero;
        @(posedge clk_in) disable iff (reset_in)
        (sym_en_in && src_code == tsc_pkg::SRC_RESERVED) |=> tx_level_out == tsc_pkg::LVL_Z;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved code not zero");

    property p_two_level;
        @(posedge clk_in) disable iff (reset_in)
        (sym_en_in && !mute && (src_code == tsc_pkg::SRC_TWO_RAW ||
         src_code == tsc_pkg::SRC_TWO_ONES)) |=> !tx_mag_out &&
        (tx_level_out == tsc_pkg::LVL_P3 || tx_level_out == tsc_pkg::LVL_M3);
    endproperty
    a_two_level: assert property (p_two_level) else $error("two-level mode gave other level");

    property p_raw_data;
        @(posedge clk_in) disable iff (reset_in)
        (sym_en_in && !mute && src_code == tsc_pkg::SRC_DATA_RAW) |=>
        tx_sign_out == $past(cu_sign_in) && tx_mag_out == $past(cu_mag_in);
    endproperty
    a_raw_data: assert property (p_raw_data) else $error("raw data not passed through");

    property p_pulse_level;
        @(posedge clk_in) disable iff (reset_in)
        (meter_fire && !mute && src_code == tsc_pkg::SRC_PULSE && pulse_code == 2'h2) |=>
        tx_level_out == tsc_pkg::LVL_P3;
    endproperty
    a_pulse_level: assert property (p_pulse_level) else $error("pulse level wrong");

    property p_reload_clears;
        @(posedge clk_in) disable iff (reset_in)
        (reload_req[tsc_pkg::METER_BIT] && sym_en_in && !wr_rel) |=>
        !reload_req[tsc_pkg::METER_BIT] && count[tsc_pkg::METER_BIT] == $past(interval[tsc_pkg::METER_BIT]);
    endproperty
    a_reload_clears: assert property (p_reload_clears) else $error("reload not done");

    property p_hold_disabled;
        @(posedge clk_in) disable iff (reset_in)
        (!count_gate[0] && !reload_req[0]) |=> count[0] == $past(count[0]);
    endproperty
    a_hold_disabled: assert property (p_hold_disabled) else $error("disabled timer moved");

    property p_stop_zero;
        @(posedge clk_in) disable iff (reset_in)
        (zero_now[6] && !continuous[6]) |=>
        count[6] == 16'h0000 ##1 (count[6] == 16'h0000 || $past(reload_now[6]));
    endproperty
    a_stop_zero: assert property (p_stop_zero) else $error("one-shot timer not at zero");

    property p_expired_set;
        @(posedge clk_in) disable iff (reset_in)
        zero_now[6] |=> expired[6];
    endproperty
    a_expired_set: assert property (p_expired_set) else $error("expiry not flagged");

    property p_boot_tick;
        @(posedge clk_in) disable iff (reset_in)
        (dec_now[0]) |-> boot_tick;
    endproperty
    a_boot_tick: assert property (p_boot_tick) else $error("boot timer off prescale");

endmodule : tsc_top

`default_nettype wire

// file: dv/tsc_cu_model.sv
// channel unit and receive detector stand-in: sign and magnitude bits for the transmitter
// assumes sym_en_in marks the symbols that the design samples on clk_in
`timescale 1ns/1ps
`default_nettype none
module tsc_cu_model (
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic sym_en_in,
    output logic      cu_sign_out,
    output logic      cu_mag_out,
    output logic      det_sign_out,
    output logic      det_mag_out
);
    logic [3:0] pat;
    // step of 7 walks all sixteen bit combinations, so every level is sent
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pat <= 4'h0;
        end else if (sym_en_in) begin
            pat <= pat + 4'h7;
        end
    end
    assign cu_sign_out  = pat[0];
    assign cu_mag_out   = pat[1];
    assign det_sign_out = pat[2];
    assign det_mag_out  = pat[3];
endmodule : tsc_cu_model
`default_nettype wire

// file: dv/testbench.sv
// self-checking bench for tsc_top: register port tasks, symbol stepping, reference scrambler
// assumes tsc_cu_model supplies the channel unit and detector bits
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clk_in    = 1'b0;
    logic       reset_in  = 1'b1;
    logic       sym_en_in = 1'b0;
    logic [7:0] addr_in   = 8'h00;
    logic [7:0] wdata_in  = 8'h00;
    logic       wr_in     = 1'b0;
    logic       rd_in     = 1'b0;
    wire  [7:0] rdata_out;
    wire  [2:0] tx_level_out;
    wire  [7:0] expired_out;
    wire        tx_sign_out, tx_mag_out, cu_s, cu_m, det_s, det_m;
    int         miscompares = 0;
    int         checks_done = 0;
    int         n, pulses;
    logic [22:0] h = 23'h000000;
    logic [2:0]  src = 3'h0;
    logic        poly = 1'b0, mute = 1'b0, chk_on = 1'b0;
    logic [7:0]  d;
    logic [15:0] c;
    logic [2:0]  lvl [4] = '{tsc_pkg::LVL_M3, tsc_pkg::LVL_M1, tsc_pkg::LVL_P3, tsc_pkg::LVL_P1};

    always #25 clk_in = ~clk_in;

    tsc_top dut_u (.clk_in(clk_in), .reset_in(reset_in), .sym_en_in(sym_en_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .cu_sign_in(cu_s), .cu_mag_in(cu_m), .det_sign_in(det_s),
        .det_mag_in(det_m), .tx_level_out(tx_level_out), .tx_sign_out(tx_sign_out),
        .tx_mag_out(tx_mag_out), .expired_out(expired_out));
    tsc_cu_model cu_u (.clk_in(clk_in), .reset_in(reset_in), .sym_en_in(sym_en_in),
        .cu_sign_out(cu_s), .cu_mag_out(cu_m), .det_sign_out(det_s), .det_mag_out(det_m));

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= v;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1 v = rdata_out;
    endtask : rd

    task automatic cnt(input logic [2:0] idx, output logic [15:0] v);
        wr(tsc_pkg::ADDR_CNT_SEL, {5'h00, idx});
        rd(tsc_pkg::ADDR_CNT_LOW, v[7:0]);
        rd(tsc_pkg::ADDR_CNT_HIGH, v[15:8]);
    endtask : cnt

    function automatic logic scr(input logic x);
        logic y;
        y = x ^ h[(poly ? tsc_pkg::TAP_REMOTE : tsc_pkg::TAP_LOCAL) - 1] ^ h[22];
        h = {h[21:0], y};
        return y;
    endfunction : scr

    // k symbols per call, one per iteration; expectations use the bits the design sampled
    task automatic sym(input int k);
        logic s, m, ds, dm, es, em;
        logic [2:0] el;
        for (int i = 0; i < k; i++) begin
            @(posedge clk_in);
            sym_en_in <= 1'b1;
            #1 {s, m, ds, dm} = {cu_s, cu_m, det_s, det_m};
            @(posedge clk_in);
            sym_en_in <= 1'b0;
            @(posedge clk_in);
            #1;
            if (chk_on) begin
                {es, em} = 2'b00;
                if (!mute) begin
                    case (src)
                        3'h1: begin es = scr(ds); em = scr(dm); end
                        3'h2: {es, em} = {s, m};
                        3'h3: begin es = scr(1'b1); em = scr(1'b1); end
                        3'h5: begin es = scr(s); em = scr(m); end
                        3'h6: es = s;
                        3'h7: es = scr(1'b1);
                        default: {es, em} = 2'b00;
                    endcase
                end
                el = em ? (es ? tsc_pkg::LVL_P1 : tsc_pkg::LVL_M1)
                        : (es ? tsc_pkg::LVL_P3 : tsc_pkg::LVL_M3);
                if (mute || src == 3'h4) el = tsc_pkg::LVL_Z;
                chk("tx_level", tx_level_out, el);
                chk("tx_bits", {tx_sign_out, tx_mag_out}, {es, em});
            end
        end
    endtask : sym

    task automatic wait_cnt(input logic [2:0] idx, input logic [15:0] v, output int k);
        logic [15:0] q;
        for (k = 1; k <= 1030; k++) begin
            sym(1);
            cnt(idx, q);
            if (q === v) break;
        end
    endtask : wait_cnt

    task automatic complete_run();
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    initial begin
        #(50 * 90000);
        miscompares++;
        complete_run();
    end

    initial begin
        repeat (8) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(8'h0b, d); chk("src_ctrl_reset", d, 8'h00);
        rd(8'h0c, d); chk("reload_reset", d, 8'h00);
        rd(8'h0d, d); chk("gate_reset", d, 8'h00);
        wr(8'h40, 8'hff);
        rd(8'h40, d); chk("unmapped", d, 8'h00);
        wr(8'h0b, 8'hff);
        rd(8'h0b, d); chk("src_ctrl_rw", d, 8'h7f);
        wr(8'h0d, 8'ha5);
        rd(8'h0d, d); chk("gate_rw", d, 8'ha5);
        wr(8'h0d, 8'h00);
        // source codes 001 to 111 under both polynomials, then mute over scrambled data
        chk_on = 1'b1;
        for (int p = 0; p < 2; p++) begin
            for (int k = 1; k < 8; k++) begin
                poly = p[0];
                src  = k[2:0];
                wr(8'h0b, {3'h0, mute, poly, src});
                sym(24);
            end
        end
        src  = 3'h5;
        mute = 1'b1;
        wr(8'h0b, {3'h0, mute, poly, src});
        sym(6);
        mute = 1'b0;
        wr(8'h0b, {3'h0, mute, poly, src});
        sym(6);
        chk_on = 1'b0;
        // meter paced isolated pulses, interval 3, continuous
        wr(8'h18, 8'h03);
        rd(8'h18, d); chk("meter_interval", d, 8'h03);
        wr(8'h0e, 8'h10);
        rd(8'h0e, d); chk("continuous_rw", d, 8'h10);
        wr(8'h0d, 8'h10);
        wr(8'h0c, 8'h10);
        wr(8'h0b, 8'h00);
        sym(1);
        for (int p = 0; p < 4; p++) begin
            wr(8'h0b, {1'b0, p[1:0], 5'h00});
            pulses = 0;
            for (int i = 0; i < 12; i++) begin
                sym(1);
                if (tx_level_out !== tsc_pkg::LVL_Z) begin
                    pulses++;
                    chk("pulse_level", tx_level_out, lvl[p]);
                end
            end
            chk("pulse_count", pulses, 4);
        end
        wr(8'h0d, 8'h00);
        wr(8'h30, 8'hff);
        rd(8'h30, d); chk("status_clear", d, 8'h00);
        // general timer a: reload, hold, count, freeze, expire
        wr(8'h1c, 8'h0a);
        wr(8'h0c, 8'h40);
        sym(1);
        rd(8'h0c, d); chk("reload_self_clear", d, 8'h00);
        sym(3);
        cnt(3'h6, c); chk("timer_a_loaded", c, 16'h000a);
        wr(8'h0d, 8'h40);
        sym(4);
        wr(8'h0d, 8'h00);
        sym(3);
        cnt(3'h6, c); chk("timer_a_frozen", c, 16'h0006);
        wr(8'h0d, 8'h40);
        wr(8'h0d, 8'h00);
        sym(2);
        cnt(3'h6, c); chk("timer_a_no_tick", c, 16'h0006);
        wr(8'h0d, 8'h40);
        sym(8);
        cnt(3'h6, c); chk("timer_a_stopped", c, 16'h0000);
        chk("expired_port", expired_out, 8'h40);
        rd(8'h30, d); chk("expired_status", d, 8'h40);
        // boot timer 0: cancelled reload, slow reload, 1024-symbol unit
        wr(8'h10, 8'h05);
        wr(8'h0c, 8'h01);
        wr(8'h0c, 8'h00);
        sym(1100);
        cnt(3'h0, c); chk("boot_cancelled", c, 16'h0000);
        wr(8'h0c, 8'h01);
        wait_cnt(3'h0, 16'h0005, n);
        chk("boot_reload_wait", n <= 1024, 1'b1);
        wr(8'h0d, 8'h01);
        wait_cnt(3'h0, 16'h0004, n);
        chk("boot_start_wait", n <= 1024, 1'b1);
        wait_cnt(3'h0, 16'h0003, n);
        chk("boot_tick_span", n, 16'd1024);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
